// ### common/thermo_pkg.sv
package thermo_pkg;

  // ----------------------------------------------------------------
  // widths and frame layout
  // ----------------------------------------------------------------
  localparam int TEMP_W = 12;
  localparam int FRAME_W = 16;
  localparam logic [3:0] FRAME_MSB_IDX = 4'hf;
  localparam logic [3:0] LAST_BIT_IDX = 4'h0;
  localparam logic [3:0] ONE_IDX = 4'h1;

  // ----------------------------------------------------------------
  // field values and reset values
  // ----------------------------------------------------------------
  localparam logic SIGN_VAL = 1'b0;
  localparam logic OPEN_OK = 1'b0;
  localparam logic PAD_VAL = 1'b0;
  // identification bit: value is arbitrary
  localparam logic DEVICE_ID = 1'b1;
  localparam logic [TEMP_W-1:0] TEMP_ZERO = 12'h000;
  localparam logic [TEMP_W-1:0] TEMP_FULL = 12'hfff;
  localparam logic CS_IDLE = 1'b1;
  localparam logic OE_N_RST = 1'b1;
  localparam logic FLAG_RST = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 20_000_000;
  localparam int CONV_TIME_MS = 220;
  localparam int CONV_CYCLES = CONV_TIME_MS * (CLOCK_HZ / 1000);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sign;
    logic [TEMP_W-1:0] temp;
    logic open;
    logic id;
    logic pad;
  } frame_t;

  typedef struct packed {
    logic [TEMP_W-1:0] cj_code;
    logic [TEMP_W-1:0] tc_code;
  } sensor_t;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_CONV = 3'b010,
    ST_LATCH = 3'b100
  } conv_state_t;

endpackage

// ### src/level_sync.sv
module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // two-stage capture; only the second stage feeds logic
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ### src/frame_shifter.sv
module frame_shifter (
  input wire logic sck,
  input wire logic cs_n,
  input wire thermo_pkg::frame_t frame,
  output logic so_data,
  output logic tri_flag
);

  logic [3:0] bit_q;

  // ----------------------------------------------------------------
  // link-side shift logic, clocked by falling serial clock
  // ----------------------------------------------------------------
  // chip select high ends the frame; sck may stand still, so the
  // frame signal itself clears the state (constants only)
  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_q <= thermo_pkg::FRAME_MSB_IDX;
      so_data <= thermo_pkg::SIGN_VAL;
      tri_flag <= thermo_pkg::FLAG_RST;
    end
    else if (bit_q != thermo_pkg::LAST_BIT_IDX)
    begin
      // next bit after each falling edge, msb first
      bit_q <= bit_q - thermo_pkg::ONE_IDX;
      so_data <= frame[bit_q - thermo_pkg::ONE_IDX];
      tri_flag <= (bit_q == thermo_pkg::ONE_IDX);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  first_bit_a: assert property (@(negedge sck) disable iff (cs_n)
    bit_q == thermo_pkg::FRAME_MSB_IDX |-> so_data == 1'b0)
    else $error("first frame bit not zero");

  shift_order_a: assert property (@(negedge sck) disable iff (cs_n)
    bit_q != thermo_pkg::LAST_BIT_IDX |=>
      so_data == frame[$past(bit_q) - thermo_pkg::ONE_IDX])
    else $error("shifted bit does not match frame");

  tail_release_a: assert property (@(negedge sck) disable iff (cs_n)
    bit_q == thermo_pkg::ONE_IDX |=> tri_flag && bit_q == 4'h0)
    else $error("last bit time not marked for release");

endmodule

// ### src/thermocouple_serial_readout.sv
// What this block does
// - result is cold-junction code plus thermocouple code, 12 bits wide
// - all-zero temperature field means zero degrees
// - all-ones temperature field means 1023.75 degrees, the top of range
// - chip select falling aborts any conversion still running on the third system clock edge after the fall
// - chip select rising starts a new conversion
// - first frame bit is driven on chip select low, before sck edges
// - frame bit fifteen is a sign bit, always zero
// - bits fourteen to three carry temperature, msb first
// - bit two is high when the thermocouple is open
// - bit one carries a fixed identification value
// - bit zero is not driven
// - serial output released once chip select rises
// - next bit shifted out after each falling sck edge
module thermocouple_serial_readout #(
  parameter int CONV_CYCLES_P = thermo_pkg::CONV_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic sck,
  input wire logic cs_n,
  input wire thermo_pkg::sensor_t sensor,
  input wire logic tc_open,
  output logic so_out,
  output logic so_oe_n
);

  localparam int CNT_W = $clog2(CONV_CYCLES_P + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES_P - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // unsigned quarter-degree sum, clipped at full scale so an overflow
  // never wraps to a low reading
  function automatic logic [thermo_pkg::TEMP_W-1:0] sat_sum(
    input logic [thermo_pkg::TEMP_W-1:0] a,
    input logic [thermo_pkg::TEMP_W-1:0] b
  );
    logic [thermo_pkg::TEMP_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s[thermo_pkg::TEMP_W])
    begin
      return thermo_pkg::TEMP_FULL;
    end
    return s[thermo_pkg::TEMP_W-1:0];
  endfunction

  // frame layout from the stored result
  function automatic thermo_pkg::frame_t make_frame(
    input logic [thermo_pkg::TEMP_W-1:0] temp,
    input logic open
  );
    thermo_pkg::frame_t f;
    f.sign = thermo_pkg::SIGN_VAL;
    f.temp = temp;
    f.open = open;
    f.id = thermo_pkg::DEVICE_ID;
    f.pad = thermo_pkg::PAD_VAL;
    return f;
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic cs_s;
  logic open_s;
  logic tri_s;
  logic tri_flag;
  logic link_data;
  thermo_pkg::conv_state_t state_q;
  thermo_pkg::conv_state_t state_d;
  logic [CNT_W-1:0] conv_cnt_q;
  logic [thermo_pkg::TEMP_W-1:0] result_q;
  logic open_q;
  thermo_pkg::frame_t frame_q;
  logic oe_n_q;

  // ----------------------------------------------------------------
  // crossings into the system clock
  // ----------------------------------------------------------------
  // chip select idles high so no read is seen during reset
  level_sync #(
    .WIDTH(1),
    .RESET_VAL(thermo_pkg::CS_IDLE)
  ) cs_sync (
    .clock(clock),
    .reset(reset),
    .async_in(cs_n),
    .sync_out(cs_s)
  );

  // open-input comparator level
  level_sync #(
    .WIDTH(1),
    .RESET_VAL(thermo_pkg::OPEN_OK)
  ) open_sync (
    .clock(clock),
    .reset(reset),
    .async_in(tc_open),
    .sync_out(open_s)
  );

  // last bit time seen on the link side
  level_sync #(
    .WIDTH(1),
    .RESET_VAL(thermo_pkg::FLAG_RST)
  ) tri_sync (
    .clock(clock),
    .reset(reset),
    .async_in(tri_flag),
    .sync_out(tri_s)
  );

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  // hold while selected, count a conversion time while released,
  // then latch one sample and start over
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      thermo_pkg::ST_HOLD:
      begin
        if (cs_s)
        begin
          state_d = thermo_pkg::ST_CONV;
        end
      end
      thermo_pkg::ST_CONV:
      begin
        if (!cs_s)
        begin
          state_d = thermo_pkg::ST_HOLD;
        end
        else if (conv_cnt_q == CNT_LAST)
        begin
          state_d = thermo_pkg::ST_LATCH;
        end
      end
      thermo_pkg::ST_LATCH:
      begin
        state_d = cs_s ? thermo_pkg::ST_CONV : thermo_pkg::ST_HOLD;
      end
      default:
      begin
        state_d = thermo_pkg::ST_HOLD;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_q <= thermo_pkg::ST_HOLD;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // conversion timer; an abort throws the partial count away
  always_ff @(posedge clock)
  begin
    if (reset || state_q != thermo_pkg::ST_CONV || !cs_s)
    begin
      conv_cnt_q <= CNT_ZERO;
    end
    else
    begin
      conv_cnt_q <= conv_cnt_q + CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // result store
  // ----------------------------------------------------------------
  // only a completed conversion replaces the result
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      result_q <= thermo_pkg::TEMP_ZERO;
      open_q <= thermo_pkg::OPEN_OK;
    end
    else if (state_q == thermo_pkg::ST_LATCH)
    begin
      result_q <= sat_sum(sensor.cj_code, sensor.tc_code);
      open_q <= open_s;
    end
  end

  // ----------------------------------------------------------------
  // outgoing frame
  // ----------------------------------------------------------------
  // tracks the result while released and freezes while selected;
  // the link side reads it as a quasi-static word, which is safe
  // because the freeze lands well before the first falling sck
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      frame_q <= make_frame(thermo_pkg::TEMP_ZERO, thermo_pkg::OPEN_OK);
    end
    else if (cs_s)
    begin
      frame_q <= make_frame(result_q, open_q);
    end
  end

  // ----------------------------------------------------------------
  // link side
  // ----------------------------------------------------------------
  // shifting runs on falling sck so the host sees settled data
  frame_shifter link_shift (
    .sck(sck),
    .cs_n(cs_n),
    .frame(frame_q),
    .so_data(link_data),
    .tri_flag(tri_flag)
  );

  assign so_out = link_data;

  // ----------------------------------------------------------------
  // output enable
  // ----------------------------------------------------------------
  // driven from selection until the last bit time; a few system
  // cycles of lag after cs edges is the price of a clean crossing
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      oe_n_q <= thermo_pkg::OE_N_RST;
    end
    else
    begin
      oe_n_q <= cs_s || tri_s;
    end
  end

  // the crossing alone would keep the last bit driven for its whole
  // bit time, so the link-side flag releases it at once
  assign so_oe_n = oe_n_q || tri_flag;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking chk_clk @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence conv_start_s;
    !cs_s ##1 cs_s;
  endsequence

  sequence conv_run_s;
    state_q == thermo_pkg::ST_CONV && conv_cnt_q == CNT_ZERO;
  endsequence

  sequence read_start_s;
    cs_s && !tri_s ##1 !cs_s;
  endsequence

  sequence conv_end_s;
    state_q == thermo_pkg::ST_CONV && cs_s && conv_cnt_q == CNT_LAST;
  endsequence

  sum_result_a: assert property (
    state_q == thermo_pkg::ST_LATCH |=>
      result_q == sat_sum($past(sensor.cj_code), $past(sensor.tc_code)))
    else $error("result is not the sum of the two codes");

  zero_code_a: assert property (
    state_q == thermo_pkg::ST_LATCH && sensor.cj_code == 12'h000 &&
      sensor.tc_code == 12'h000 |=> result_q == 12'h000)
    else $error("zero inputs did not give zero code");

  full_scale_a: assert property (
    state_q == thermo_pkg::ST_LATCH &&
      ({1'b0, sensor.cj_code} + {1'b0, sensor.tc_code}) >= 13'h0fff
      |=> result_q == 12'hfff)
    else $error("full scale not all ones");

  abort_conv_a: assert property (
    !cs_s |=> state_q == thermo_pkg::ST_HOLD && conv_cnt_q == CNT_ZERO)
    else $error("conversion kept running while selected");

  start_conv_a: assert property (
    conv_start_s |=> conv_run_s)
    else $error("conversion did not start on release");

  drive_first_a: assert property (
    read_start_s |=> !so_oe_n)
    else $error("output not driven after select");

  open_flag_a: assert property (
    state_q == thermo_pkg::ST_LATCH ##1 cs_s |=> frame_q.open == open_q)
    else $error("open flag not carried into frame");

  frame_id_a: assert property (
    frame_q.id == thermo_pkg::DEVICE_ID && frame_q.sign == 1'b0)
    else $error("fixed frame bits wrong");

  release_a: assert property (
    cs_s |=> so_oe_n)
    else $error("output driven while deselected");

  frame_hold_a: assert property (
    !cs_s ##1 !cs_s |-> $stable(frame_q))
    else $error("frame changed during a read");

  count_end_a: assert property (
    conv_end_s |=> state_q == thermo_pkg::ST_LATCH)
    else $error("full count did not latch a result");

  latch_once_a: assert property (
    state_q == thermo_pkg::ST_LATCH |=> state_q != thermo_pkg::ST_LATCH)
    else $error("result latched twice in a row");

  hold_idle_a: assert property (
    state_q == thermo_pkg::ST_HOLD |-> conv_cnt_q == CNT_ZERO)
    else $error("count not cleared while held");

  result_keep_a: assert property (
    state_q != thermo_pkg::ST_LATCH |=> $stable(result_q) && $stable(open_q))
    else $error("result changed outside a latch");

  frame_track_a: assert property (
    cs_s |=> frame_q == make_frame($past(result_q), $past(open_q)))
    else $error("frame does not follow the result while released");

endmodule

// ### verif/host_reader.sv
// ----------------------------------------------------------------
// host side of the serial read: chip select, serial clock, sampling
// ----------------------------------------------------------------
module host_reader (
  output logic cs_n,
  output logic sck,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle: deselected, serial clock stands low outside frames; select
  // rises just after start so the link side sees a clean preset edge
  initial
  begin
    sck = 1'h0;
    #1;
    cs_n = 1'h1;
  end

  // one full read; period 80 ns, phase free against the system clock
  task automatic read_frame(output logic [15:0] word);
    int i;
    begin
      #7;
      cs_n = 1'h0;
      // frame must be frozen before the first edge, so allow setup
      #200;
      for (i = 15; i >= 0; i--)
      begin
        sck = 1'h1;
        #40;
        word[i] = so;
        sck = 1'h0;
        #40;
      end
      // stay selected until the release has crossed into the system
      // clock, so the enable does not blink on as select rises
      #200;
      cs_n = 1'h1;
    end
  endtask
endmodule

// ### verif/tb_thermocouple_serial_readout.sv
module tb_thermocouple_serial_readout;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------
  // short conversion keeps the run brief
  localparam int CONV_P = 50;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic tc_open = 1'h0;
  logic sck;
  logic cs_n;
  logic so_out;
  logic so_oe_n;
  thermo_pkg::sensor_t sensor = '0;
  wire so_wire;
  int mismatches = 0;
  int n_checks = 0;
  logic [15:0] word;

  typedef struct {
    logic [11:0] cj;
    logic [11:0] tc;
    logic open;
    logic [11:0] temp;
  } row_t;

  row_t rows [6] = '{
    '{12'h000, 12'h000, 1'h0, 12'h000},
    '{12'h7ff, 12'h800, 1'h0, 12'hfff},
    '{12'h900, 12'h900, 1'h0, 12'hfff},
    '{12'h123, 12'h456, 1'h1, 12'h579},
    '{12'h001, 12'h002, 1'h0, 12'h003},
    '{12'ha00, 12'h05a, 1'h0, 12'ha5a}
  };

  // output pin resolves to high impedance when not enabled
  assign so_wire = so_oe_n ? 1'hz : so_out;

  always #25 clock = ~clock;

  thermocouple_serial_readout #(
    .CONV_CYCLES_P(CONV_P)
  ) dut_u (
    .clock(clock),
    .reset(reset),
    .sck(sck),
    .cs_n(cs_n),
    .sensor(sensor),
    .tc_open(tc_open),
    .so_out(so_out),
    .so_oe_n(so_oe_n)
  );

  host_reader host_u (
    .cs_n(cs_n),
    .sck(sck),
    .so(so_wire)
  );

  // ----------------------------------------------------------------
  // checking and reporting
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one read: bits fifteen to one compared as one word against the expected frame, bit zero against high impedance
  task automatic read_expect(input string name, input logic [11:0] temp,
                             input logic open);
    host_u.read_frame(word);
    check(name, {1'h0, word[15:1]}, {1'h0, thermo_pkg::SIGN_VAL, temp,
      open, thermo_pkg::DEVICE_ID});
    check({name, "_d0"}, {15'h0000, word[0]}, {15'h0000, 1'hz});
    repeat (4) @(negedge clock);
    check({name, "_idle"}, {15'h0000, so_oe_n}, 16'h0001);
    $display("test %s done", name);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  // one read out of reset, then rows, then the awkward cases: abort, restart, mid-run reset
  initial
  begin
    repeat (12) @(negedge clock);
    sensor = {12'h111, 12'h222};
    check("oe_in_reset", {15'h0000, so_oe_n}, 16'h0001);
    reset = 1'h0;
    // read at once: no conversion has finished yet
    read_expect("after_reset", 12'h000, 1'h0);
    for (int r = 0; r < 6; r++)
    begin
      @(negedge clock);
      sensor = {rows[r].cj, rows[r].tc};
      tc_open = rows[r].open;
      repeat (80) @(negedge clock);
      read_expect($sformatf("row%0d", r), rows[r].temp,
        rows[r].open);
    end
    // too short a high time: the read aborts the conversion, old result stays
    @(negedge clock);
    sensor = {12'h0aa, 12'h000};
    repeat (30) @(negedge clock);
    read_expect("abort", rows[5].temp, 1'h0);
    // second short gap: the old result survives only if the count that
    // ran before the last read was thrown away
    repeat (30) @(negedge clock);
    read_expect("abort_again", rows[5].temp, 1'h0);
    repeat (80) @(negedge clock);
    read_expect("restart", 12'h0aa, 1'h0);
    // reset in mid-run: result and frame fall back to zero
    @(negedge clock);
    reset = 1'h1;
    repeat (3) @(negedge clock);
    check("oe_mid_reset", {15'h0000, so_oe_n}, 16'h0001);
    reset = 1'h0;
    read_expect("reset_again", 12'h000, 1'h0);
    close_out();
  end

  // watchdog: whole sequence needs about a thousand cycles
  initial
  begin
    repeat (4000) @(posedge clock);
    mismatches++;
    $display("watchdog expired");
    close_out();
  end
endmodule
